// ### shared/crc_input_cfg.svh
// Register map, field positions and reset values of the checksum input block
`ifndef CRC_INPUT_CFG_SVH
`define CRC_INPUT_CFG_SVH

// ==========================================================================
// Register byte offsets
`define OFF_CONTROL      12'h000
`define OFF_IRQ_ENABLES  12'h020
`define OFF_EVENT_FLAGS  12'h024
`define OFF_INPUT_WORD   12'h080

// ==========================================================================
// Field positions
`define BIT_TRIGGER_EN   23
`define BIT_DMA_MODE     0
`define BIT_DMA_RESET    1
`define LSB_OPLEN        2
`define BIT_DONE         1
`define BIT_ABORT        0

// ==========================================================================
// Reset values
`define RST_CONTROL      32'h0000_0000
`define RST_IRQ_ENABLES  2'h1
`define RST_INPUT_WORD   32'h0000_0000

// ==========================================================================
// Operand length codes
`define OPLEN_8          2'h0
`define OPLEN_16         2'h1
`define OPLEN_32         2'h2

`endif

// ### shared/crc_input_pkg.sv
// Types shared by the checksum input block
package crc_input_pkg;

  // ========================================================================
  // Engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_WAIT = 3'b100
  } engine_state_t;

  // ========================================================================
  // One operand handed to the checksum core
  typedef struct packed {
    logic        valid;
    logic [1:0]  len;
    logic [31:0] data;
  } operand_t;

  // ========================================================================
  // DMA read beat returned by the memory side
  typedef struct packed {
    logic        valid;
    logic        error;
    logic        last;
    logic [31:0] data;
  } dma_beat_t;

endpackage

// ### src/crc_input_block.sv
// Event flags, abort recovery and operand input of the checksum engine
`timescale 1ns/1ps
`include "crc_input_cfg.svh"

// Operation
// R1: Done flag sets when triggered DMA finishes
// R2: Trigger enable self-clears at transfer end
// R3: Event flags stay set until written one
// R4: Bus error during DMA sets abort flag
// R5: Bus error stops DMA, engine goes idle
// R6: Software resets DMA before retrying
// R7: Processor writes feed checksum in PIO mode
// R8: DMA mode: word shows DMA data, writes ignored
// R9: Narrow lengths use only low bits
// R10: Done enable raises irq while done set
// R11: Abort enable raises irq, resets to one
// R12: Zero writes keep flags; irq ORs enabled
module crc_input_block
  import crc_input_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire dma_beat_t   dma_beat,
  output logic             dma_req,
  output operand_t         operand,
  output logic             irq
);

  // ========================================================================
  // Helpers
  function automatic logic [31:0] mask_len(input logic [1:0] len,
                                           input logic [31:0] d);
    case (len)
      `OPLEN_8:  mask_len = {24'h000000, d[7:0]};
      `OPLEN_16: mask_len = {16'h0000, d[15:0]};
      default:   mask_len = d;
    endcase
  endfunction

  // ========================================================================
  // Bus decode
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] control_r;
  logic [1:0]  irq_en_r;
  logic [1:0]  flags_r;
  logic [31:0] input_word_r;
  logic        prev_done_r;
  engine_state_t state_r;
  logic        trig;
  logic        dma_mode;
  logic [1:0]  oplen;
  logic        beat_ok;
  logic        beat_err;
  logic        dma_rst;

  assign acc   = psel && penable && !pready;
  // Writes land on the ready edge, where the master completes the transfer
  assign wr    = psel && penable && pready && pwrite;
  assign hit   = paddr == `OFF_CONTROL || paddr == `OFF_IRQ_ENABLES ||
                 paddr == `OFF_EVENT_FLAGS || paddr == `OFF_INPUT_WORD;
  assign trig     = control_r[`BIT_TRIGGER_EN];
  assign dma_mode = control_r[`BIT_DMA_MODE];
  assign oplen    = control_r[`LSB_OPLEN+1:`LSB_OPLEN];
  assign beat_ok  = state_r == ST_BUSY && dma_beat.valid && !dma_beat.error;
  assign beat_err = state_r == ST_BUSY && dma_beat.valid && dma_beat.error;
  assign dma_rst  = wr && paddr == `OFF_CONTROL && pwdata[`BIT_DMA_RESET];

  // One wait state: answer comes on the second access edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc && !hit;
      if (acc && !pwrite) begin
        case (paddr)
          `OFF_CONTROL:     prdata <= control_r;
          `OFF_IRQ_ENABLES: prdata <= {30'h0, irq_en_r};
          `OFF_EVENT_FLAGS: prdata <= {30'h0, flags_r};
          `OFF_INPUT_WORD:  prdata <= input_word_r;
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ========================================================================
  // Control register
  always_ff @(posedge mclk) begin
    if (srst) begin
      control_r <= `RST_CONTROL;
    end else begin
      if (wr && paddr == `OFF_CONTROL) begin
        control_r <= pwdata;
        control_r[`BIT_DMA_RESET] <= 1'b0;
      end
      if (state_r == ST_BUSY && dma_beat.valid &&
          (dma_beat.last || dma_beat.error)) begin
        control_r[`BIT_TRIGGER_EN] <= 1'b0; // [R2]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en_r <= `RST_IRQ_ENABLES; // [R11]
    end else if (wr && paddr == `OFF_IRQ_ENABLES) begin
      irq_en_r <= pwdata[1:0];
    end
  end

  // ========================================================================
  // Engine state; a bus error drops back to idle at once
  always_ff @(posedge mclk) begin
    if (srst || dma_rst) begin
      state_r <= ST_IDLE; // [R6]
    end else begin
      case (state_r)
        ST_IDLE: if (trig && dma_mode) state_r <= ST_BUSY;
        ST_BUSY: begin
          if (beat_err) state_r <= ST_IDLE; // [R5]
          else if (beat_ok && dma_beat.last) state_r <= ST_WAIT;
        end
        ST_WAIT: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    // Software reset must drop the request with the engine, or a stray
    // beat would be offered while idle
    if (srst || dma_rst) begin
      dma_req <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      dma_req <= trig && dma_mode;
    end else begin
      dma_req <= state_r == ST_BUSY && !beat_err &&
                 !(beat_ok && dma_beat.last); // [R5]
    end
  end

  // ========================================================================
  // Event flags: set wins over a simultaneous clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      flags_r <= 2'h0;
    end else begin
      if (wr && paddr == `OFF_EVENT_FLAGS) begin
        flags_r <= flags_r & ~pwdata[1:0]; // [R3] [R12]
      end
      if (beat_ok && dma_beat.last) flags_r[`BIT_DONE] <= 1'b1; // [R1]
      if (beat_err) flags_r[`BIT_ABORT] <= 1'b1; // [R4]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) irq <= 1'b0;
    else irq <= |(flags_r & irq_en_r); // [R10] [R11] [R12]
  end

  // ========================================================================
  // Input word and operand stream
  always_ff @(posedge mclk) begin
    if (srst) begin
      input_word_r <= `RST_INPUT_WORD;
      operand      <= '0;
    end else begin
      operand.valid <= 1'b0;
      if (dma_mode) begin
        if (beat_ok) begin
          input_word_r  <= dma_beat.data; // [R8]
          operand.valid <= 1'b1;
          operand.len   <= oplen;
          operand.data  <= mask_len(oplen, dma_beat.data); // [R9]
        end
      end else if (wr && paddr == `OFF_INPUT_WORD) begin
        input_word_r  <= pwdata; // [R7]
        operand.valid <= 1'b1;
        operand.len   <= oplen;
        operand.data  <= mask_len(oplen, pwdata); // [R9]
      end
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence last_beat_s;
    beat_ok && dma_beat.last;
  endsequence

  done_sets_a: assert property (last_beat_s |=> flags_r[1]) // [R1]
    else $error("done flag not set");
  trig_clear_a: assert property (last_beat_s |=> !trig) // [R2]
    else $error("trigger not cleared");
  flag_hold_a: assert property (flags_r[0] && !(wr &&
      paddr == `OFF_EVENT_FLAGS && pwdata[0]) |=> flags_r[0]) // [R3]
    else $error("abort flag lost");
  abort_sets_a: assert property (beat_err |=> flags_r[0] && !dma_req) // [R4]
    else $error("abort flag not set");
  abort_idle_a: assert property (beat_err |=> state_r == ST_IDLE) // [R5]
    else $error("engine not idle after abort");
  pio_write_a: assert property (wr && paddr == `OFF_INPUT_WORD && !dma_mode
      |=> operand.valid && input_word_r == $past(pwdata)) // [R7]
    else $error("pio write not taken");
  dma_ignore_a: assert property (dma_mode && !beat_ok
      |=> $stable(input_word_r)) // [R8]
    else $error("input word changed in dma mode");
  narrow_a: assert property (operand.valid && operand.len == `OPLEN_8
      |-> operand.data[31:8] == 24'h0) // [R9]
    else $error("upper bits leaked");
  irq_or_a: assert property (##1 irq == $past(|(flags_r & irq_en_r)))
    // [R10] [R11] [R12]
    else $error("irq mismatch");

  // ========================================================================
  // Bus protocol checks
  sequence access_s;
    psel && penable && !pready;
  endsequence

  ready_pulse_a: assert property (access_s |=> pready)
    else $error("no ready after access");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  slverr_unmapped_a: assert property (acc && !hit |=> pslverr)
    else $error("unmapped access not refused");
  slverr_mapped_a: assert property (acc && hit |=> !pslverr)
    else $error("mapped access refused");

  unmapped_read_a: assert property (
      acc && !pwrite && !hit
      |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Read data is captured on the access edge, the same edge that raises ready
  read_ctrl_a: assert property ( // [R2]
      acc && !pwrite && paddr == `OFF_CONTROL
      |=> prdata == $past(control_r))
    else $error("control read mismatch");

  read_en_a: assert property ( // [R11]
      acc && !pwrite && paddr == `OFF_IRQ_ENABLES
      |=> prdata == {30'h0, $past(irq_en_r)})
    else $error("enable read mismatch");

  read_flags_a: assert property ( // [R3]
      acc && !pwrite && paddr == `OFF_EVENT_FLAGS
      |=> prdata == {30'h0, $past(flags_r)})
    else $error("flag read mismatch");

  read_word_a: assert property ( // [R8]
      acc && !pwrite && paddr == `OFF_INPUT_WORD
      |=> prdata == $past(input_word_r))
    else $error("input word read mismatch");

  // ========================================================================
  // Register write checks
  ctrl_write_a: assert property ( // [R7]
      wr && paddr == `OFF_CONTROL
      |=> control_r[`BIT_DMA_MODE] == $past(pwdata[`BIT_DMA_MODE]))
    else $error("mode bit not written");

  en_write_a: assert property ( // [R11]
      wr && paddr == `OFF_IRQ_ENABLES
      |=> irq_en_r == $past(pwdata[1:0]))
    else $error("enables not written");

  // ========================================================================
  // Event flag checks
  done_clear_a: assert property ( // [R3]
      wr && paddr == `OFF_EVENT_FLAGS && pwdata[`BIT_DONE] &&
      !(beat_ok && dma_beat.last)
      |=> !flags_r[`BIT_DONE])
    else $error("done flag not cleared");

  abort_clear_a: assert property ( // [R3]
      wr && paddr == `OFF_EVENT_FLAGS && pwdata[`BIT_ABORT] && !beat_err
      |=> !flags_r[`BIT_ABORT])
    else $error("abort flag not cleared");

  done_hold_a: assert property ( // [R12]
      flags_r[`BIT_DONE] &&
      !(wr && paddr == `OFF_EVENT_FLAGS && pwdata[`BIT_DONE])
      |=> flags_r[`BIT_DONE])
    else $error("done flag lost");

  zero_write_a: assert property ( // [R12]
      wr && paddr == `OFF_EVENT_FLAGS && pwdata[1:0] == 2'h0
      |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("zero write cleared a flag");

  done_cause_a: assert property ( // [R1]
      $rose(flags_r[`BIT_DONE]) |-> $past(beat_ok && dma_beat.last))
    else $error("done flag without last beat");

  abort_cause_a: assert property ( // [R4]
      $rose(flags_r[`BIT_ABORT]) |-> $past(beat_err))
    else $error("abort flag without bus error");

  // ========================================================================
  // Engine and request checks
  sequence err_beat_s;
    beat_err;
  endsequence

  state_onehot_a: assert property ($onehot(state_r))
    else $error("engine state not one-hot");
  busy_req_a: assert property (dma_req == (state_r == ST_BUSY)) // [R5]
    else $error("request disagrees with engine state");
  abort_trig_a: assert property (err_beat_s |=> !trig) // [R5]
    else $error("trigger kept after abort");
  wait_idle_a: assert property (state_r == ST_WAIT |=> state_r == ST_IDLE)
    else $error("engine stuck after transfer");

  start_busy_a: assert property ( // [R1]
      state_r == ST_IDLE && trig && dma_mode && !dma_rst
      |=> dma_req && state_r == ST_BUSY)
    else $error("triggered transfer not started");

  last_stop_a: assert property ( // [R1]
      beat_ok && dma_beat.last && !dma_rst
      |=> !dma_req && state_r == ST_WAIT)
    else $error("request kept after last beat");

  dma_reset_a: assert property ( // [R6]
      dma_rst
      |=> state_r == ST_IDLE && !dma_req && !control_r[`BIT_DMA_RESET])
    else $error("software reset not applied");

  // ========================================================================
  // Operand checks
  dma_word_a: assert property ( // [R8]
      beat_ok && dma_mode
      |=> input_word_r == $past(dma_beat.data) && operand.valid)
    else $error("dma beat not taken");

  dma_wr_ignore_a: assert property ( // [R8]
      wr && paddr == `OFF_INPUT_WORD && dma_mode && !beat_ok
      |=> !operand.valid && $stable(input_word_r))
    else $error("processor write taken in dma mode");

  pio_low_a: assert property ( // [R9]
      wr && paddr == `OFF_INPUT_WORD && !dma_mode
      |=> operand.data[7:0] == $past(pwdata[7:0]))
    else $error("low byte of operand lost");

  narrow16_a: assert property ( // [R9]
      operand.valid && operand.len == `OPLEN_16
      |-> operand.data[31:16] == 16'h0000)
    else $error("upper half leaked");

  // ========================================================================
  // Interrupt checks
  irq_done_a: assert property ( // [R10]
      flags_r[`BIT_DONE] && irq_en_r[`BIT_DONE] |=> irq)
    else $error("done interrupt missing");

  irq_abort_a: assert property ( // [R11]
      flags_r[`BIT_ABORT] && irq_en_r[`BIT_ABORT] |=> irq)
    else $error("abort interrupt missing");

  irq_quiet_a: assert property ( // [R12]
      !(|(flags_r & irq_en_r)) |=> !irq)
    else $error("interrupt without enabled flag");

endmodule

// ### verif/dma_mem_model.sv
// Memory read side that answers the DMA master of the checksum block
`timescale 1ns/1ps
module dma_mem_model
  import crc_input_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       dma_req,
  input  wire logic       slow,
  input  wire logic [7:0] n_beats,
  input  wire logic [7:0] err_at,
  output dma_beat_t       dma_beat
);
  logic [7:0]  idx_r;
  logic [31:0] tick_r;

  // ========================================================================
  // Beat sequencing
  always_ff @(posedge mclk) begin
    tick_r <= srst ? 32'h0000_0000 : tick_r + 32'h0000_0001;
    if (srst || !dma_req) begin
      idx_r <= 8'h00;
    end else if (dma_beat.valid) begin
      idx_r <= idx_r + 8'h01;
    end
  end

  // Idle data keeps changing so a stale word is never mistaken for a beat
  always_comb begin
    dma_beat.valid = dma_req && idx_r < n_beats && (tick_r[0] || !slow);
    dma_beat.last  = idx_r == n_beats - 8'h01;
    dma_beat.error = idx_r == err_at;
    dma_beat.data  = dma_beat.valid ? 32'hC0DE_0000 + idx_r : ~tick_r;
  end
endmodule

// ### verif/test_crc_input_block.sv
// Self-checking testbench of the checksum input block
`timescale 1ns/1ps
`include "crc_input_cfg.svh"
module test_crc_input_block
  import crc_input_pkg::*;
;
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr;
  logic        dma_req, irq, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  n_beats, err_at;
  dma_beat_t   dma_beat;
  operand_t    operand, op_last;
  int          op_n = 0, n0, n_fail = 0, check_count = 0;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  crc_input_block u_dut (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_beat(dma_beat), .dma_req(dma_req), .operand(operand), .irq(irq));
  dma_mem_model u_mem (.mclk(mclk), .srst(srst), .dma_req(dma_req),
    .slow(slow), .n_beats(n_beats), .err_at(err_at), .dma_beat(dma_beat));

  always @(posedge mclk) begin
    if (operand.valid === 1'b1) begin
      op_n <= op_n + 1;
      op_last <= operand;
    end
  end

  // ========================================================================
  // Bus and compare helpers
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Engine finishing is seen only through the flags, so poll them
  task automatic poll();
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, `OFF_EVENT_FLAGS, 32'h0000_0000);
      if (rd !== 32'h0000_0000) break;
    end
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    rdchk(`OFF_IRQ_ENABLES, 32'h0000_0001);
    rdchk(`OFF_EVENT_FLAGS, 32'h0000_0000);
    rdchk(`OFF_INPUT_WORD, 32'h0000_0000);
    chk(irq, 32'h0000_0000);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    chk(err, 32'h0000_0001);
    $display("reset and unmapped done");
  endtask

  task automatic t_pio();
    logic [31:0] m;
    for (int i = 0; i < 3; i++) begin
      m = i == 0 ? 32'h0000_00FF : i == 1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      apb(1'b1, `OFF_CONTROL, 32'(i) << 2);
      n0 = op_n;
      apb(1'b1, `OFF_INPUT_WORD, 32'hA5A5_5A5A ^ 32'(i));
      repeat (2) @(posedge mclk);
      chk(32'(op_n - n0), 32'h0000_0001);
      chk(op_last.data, (32'hA5A5_5A5A ^ 32'(i)) & m);
      chk(op_last.len, 32'(i));
    end
    $display("processor input done");
  endtask

  task automatic t_dma();
    n_beats <= 8'h04;
    err_at <= 8'hFF;
    slow <= 1'b0;
    apb(1'b1, `OFF_IRQ_ENABLES, 32'h0000_0003);
    n0 = op_n;
    apb(1'b1, `OFF_CONTROL, 32'h0080_0009);
    poll();
    chk(rd, 32'h0000_0002);
    chk(32'(op_n - n0), 32'h0000_0004);
    chk(irq, 32'h0000_0001);
    rdchk(`OFF_CONTROL, 32'h0000_0009);
    rdchk(`OFF_INPUT_WORD, 32'hC0DE_0003);
    n0 = op_n;
    apb(1'b1, `OFF_INPUT_WORD, 32'h1234_5678);
    rdchk(`OFF_INPUT_WORD, 32'hC0DE_0003);
    chk(32'(op_n - n0), 32'h0000_0000);
    apb(1'b1, `OFF_EVENT_FLAGS, 32'h0000_0000);
    rdchk(`OFF_EVENT_FLAGS, 32'h0000_0002);
    apb(1'b1, `OFF_EVENT_FLAGS, 32'h0000_0002);
    rdchk(`OFF_EVENT_FLAGS, 32'h0000_0000);
    chk(irq, 32'h0000_0000);
    $display("dma transfer done");
  endtask

  task automatic t_abort();
    slow <= 1'b1;
    err_at <= 8'h01;
    apb(1'b1, `OFF_CONTROL, 32'h0080_0009);
    poll();
    chk(rd, 32'h0000_0001);
    chk(dma_req, 32'h0000_0000);
    chk(irq, 32'h0000_0001);
    rdchk(`OFF_CONTROL, 32'h0000_0009);
    apb(1'b1, `OFF_IRQ_ENABLES, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk(irq, 32'h0000_0000);
    apb(1'b1, `OFF_EVENT_FLAGS, 32'h0000_0001);
    rdchk(`OFF_EVENT_FLAGS, 32'h0000_0000);
    apb(1'b1, `OFF_CONTROL, 32'h0000_000B);
    err_at <= 8'hFF;
    apb(1'b1, `OFF_CONTROL, 32'h0080_0009);
    poll();
    chk(rd, 32'h0000_0002);
    $display("abort and retry done");
  endtask

  // ========================================================================
  // Verdict and main sequence
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    summarize();
  end

  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_beats = 8'h00;
    err_at = 8'hFF;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_pio();
    t_dma();
    t_abort();
    summarize();
  end
endmodule
